// ==== verilog/sle_pkg.sv ====
// constants and types of the status lamp encoder
// assumes one 100 MHz module clock and a synchronous active-low reset
package sle_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int          CHANNELS      = 8;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          FLASH_HALF_MS = 250;
  localparam int          FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int          DIV_W         = 25;
  localparam logic [24:0] DIV_RESET     = 25'h0000000;

  // ----------------------------------------
  // lamp patterns
  // ----------------------------------------
  typedef enum logic [6:0] {
    SLE_MODE_DARK  = 7'h01,
    SLE_MODE_START = 7'h02,
    SLE_MODE_RUN   = 7'h04,
    SLE_MODE_FWUP  = 7'h08,
    SLE_MODE_DIAG  = 7'h10,
    SLE_MODE_HWDEF = 7'h20,
    SLE_MODE_ACK   = 7'h40
  } sle_mode_e;

  typedef enum logic [4:0] {
    SLE_CH_NORMAL   = 5'h01,
    SLE_CH_MISMATCH = 5'h02,
    SLE_CH_IDENT    = 5'h04,
    SLE_CH_SUPPLY   = 5'h08,
    SLE_CH_FORCE    = 5'h10
  } sle_chmode_e;

endpackage : sle_pkg

// ==== verilog/sle_flash_div.sv ====
// flash phase divider for the status lamp encoder
// assumes MCLK at the rate in sle_pkg
module sle_flash_div (
  input  wire logic MCLK,
  input  wire logic RST_B,
  output logic      PHASE
);

  logic [sle_pkg::DIV_W-1:0] cnt_reg;
  logic                      phase_reg;

  // one counter feeds every flashing lamp so they stay in step
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      cnt_reg <= sle_pkg::DIV_RESET;
    end else if (cnt_reg ==
                 sle_pkg::DIV_W'(sle_pkg::FLASH_HALF_CYC - 1)) begin
      cnt_reg <= sle_pkg::DIV_RESET;
    end else begin
      cnt_reg <= cnt_reg + sle_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      phase_reg <= 1'b0;
    end else if (cnt_reg ==
                 sle_pkg::DIV_W'(sle_pkg::FLASH_HALF_CYC - 1)) begin
      phase_reg <= ~phase_reg;
    end
  end

  assign PHASE = phase_reg;

endmodule // sle_flash_div

// ==== verilog/sle_top.sv ====
// front-panel lamp encoder of a fail-safe output module
// inputs are levels from the module's own state machines, synchronous
// to MCLK; lamp outputs are registered, 1 = lit
module sle_top (
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  input  wire logic       BACKPLANE_OK,
  input  wire logic       PARAM_VALID,
  input  wire logic       ADDRESSED,
  input  wire logic       FW_UPDATE,
  input  wire logic       HW_DEFECT,
  input  wire logic       MODULE_FAULT,
  input  wire logic       SAFETY_COMM_ERR,
  input  wire logic       NEW_GEN_HOST,
  input  wire logic       MODULE_ACK_PEND,
  input  wire logic       ADDR_MISMATCH,
  input  wire logic       ADDR_IDENTIFY,
  input  wire logic       SUPPLY_ERR,
  input  wire logic       USER_ACK,
  input  wire logic       LOAD_SUPPLY_OK,
  input  wire logic [7:0] PROC_SIGNAL,
  input  wire logic [7:0] CH_DIAG,
  input  wire logic [7:0] CH_ACK_PEND,
  input  wire logic [7:0] CH_CHAIN_WAIT,
  output logic            RUN_LAMP,
  output logic            ERROR_LAMP,
  output logic            SUPPLY_LAMP,
  output logic [7:0]      CHANNEL_LAMP_N,
  output logic [7:0]      CHANNEL_DIAG_LAMP,
  output logic [7:0]      PROC_OUT,
  output logic            SUPPLY_FAULT_SHOWN
);

  localparam int N = sle_pkg::CHANNELS;

  logic                phase;
  logic                supply_hold_reg;
  logic                supply_hold_next;
  logic                supply_show;
  logic                ch_wait_any;
  logic                diag_any;
  logic                run_next;
  logic                err_next;
  logic [N-1:0]        st_next;
  logic [N-1:0]        dg_next;
  logic                run_reg;
  logic                err_reg;
  logic                pwr_reg;
  logic [N-1:0]        st_reg;
  logic [N-1:0]        dg_reg;
  logic [N-1:0]        proc_reg;
  sle_pkg::sle_mode_e   mode;
  sle_pkg::sle_chmode_e chmode;

  // ----------------------------------------
  // shared flash phase
  // ----------------------------------------
  sle_flash_div sle_flash_div_inst (
    .MCLK  (MCLK),
    .RST_B (RST_B),
    .PHASE (phase)
  );

  // ----------------------------------------
  // supply fault latch
  // ----------------------------------------
  // newer host keeps the fault shown until acknowledged; a new error in
  // the acknowledge cycle wins over the clear
  always_comb begin
    supply_hold_next = supply_hold_reg;
    if (SUPPLY_ERR && NEW_GEN_HOST) begin
      supply_hold_next = 1'b1;
    end else if (USER_ACK || !NEW_GEN_HOST) begin
      supply_hold_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      supply_hold_reg <= 1'b0;
    end else begin
      supply_hold_reg <= supply_hold_next;
    end
  end

  // older host: the live error alone decides, so it clears on correction
  assign supply_show = SUPPLY_ERR || supply_hold_reg;

  // ----------------------------------------
  // run / error pattern selection
  // ----------------------------------------
  assign ch_wait_any = |CH_ACK_PEND;
  assign diag_any    = MODULE_FAULT || SAFETY_COMM_ERR || (|CH_DIAG) ||
                       (NEW_GEN_HOST && ch_wait_any);

  // fixed priority: dark backplane, defect, update, address, supply, ack, diag, run
  always_comb begin
    if (!BACKPLANE_OK) begin
      mode = sle_pkg::SLE_MODE_DARK;
    end else if (HW_DEFECT) begin
      mode = sle_pkg::SLE_MODE_HWDEF;
    end else if (FW_UPDATE) begin
      mode = sle_pkg::SLE_MODE_FWUP;
    end else if (ADDR_MISMATCH || ADDR_IDENTIFY) begin
      mode = sle_pkg::SLE_MODE_FWUP;
    end else if (supply_show) begin
      mode = sle_pkg::SLE_MODE_DIAG;
    end else if ((NEW_GEN_HOST && MODULE_ACK_PEND) ||
                 (!NEW_GEN_HOST && ch_wait_any)) begin
      mode = sle_pkg::SLE_MODE_ACK;
    end else if (diag_any) begin
      mode = sle_pkg::SLE_MODE_DIAG;
    end else if (PARAM_VALID && ADDRESSED) begin
      mode = sle_pkg::SLE_MODE_RUN;
    end else begin
      mode = sle_pkg::SLE_MODE_START;
    end
  end

  // address indications keep the run lamp as the update pattern: dark
  always_comb begin
    case (mode)
      sle_pkg::SLE_MODE_DARK: begin
        run_next = 1'b0;
        err_next = 1'b0;
      end
      sle_pkg::SLE_MODE_START: begin
        run_next = phase;
        err_next = 1'b0;
      end
      sle_pkg::SLE_MODE_RUN: begin
        run_next = 1'b1;
        err_next = 1'b0;
      end
      sle_pkg::SLE_MODE_FWUP: begin
        run_next = 1'b0;
        err_next = phase;
      end
      sle_pkg::SLE_MODE_DIAG: begin
        run_next = 1'b1;
        err_next = phase;
      end
      sle_pkg::SLE_MODE_HWDEF: begin
        run_next = phase;
        err_next = phase;
      end
      sle_pkg::SLE_MODE_ACK: begin
        run_next = phase;
        err_next = ~phase;
      end
      default: begin
        run_next = 1'b0;
        err_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // channel lamps
  // ----------------------------------------
  always_comb begin
    if (!BACKPLANE_OK || HW_DEFECT || FW_UPDATE) begin
      chmode = sle_pkg::SLE_CH_FORCE;
    end else if (ADDR_MISMATCH) begin
      chmode = sle_pkg::SLE_CH_MISMATCH;
    end else if (ADDR_IDENTIFY) begin
      chmode = sle_pkg::SLE_CH_IDENT;
    end else if (supply_show) begin
      chmode = sle_pkg::SLE_CH_SUPPLY;
    end else begin
      chmode = sle_pkg::SLE_CH_NORMAL;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (chmode)
        sle_pkg::SLE_CH_MISMATCH: begin
          st_next[i] = 1'b0;
          dg_next[i] = 1'b1;
        end
        sle_pkg::SLE_CH_IDENT: begin
          st_next[i] = phase;
          dg_next[i] = 1'b0;
        end
        sle_pkg::SLE_CH_SUPPLY: begin
          st_next[i] = 1'b0;
          dg_next[i] = 1'b1;
        end
        sle_pkg::SLE_CH_NORMAL: begin
          if (CH_ACK_PEND[i] ||
              (!NEW_GEN_HOST && CH_CHAIN_WAIT[i] && ch_wait_any)) begin
            st_next[i] = phase;
            dg_next[i] = ~phase;
          end else if (CH_DIAG[i]) begin
            st_next[i] = 1'b0;
            dg_next[i] = 1'b1;
          end else begin
            st_next[i] = PROC_SIGNAL[i];
            dg_next[i] = 1'b0;
          end
        end
        default: begin
          st_next[i] = 1'b0;
          dg_next[i] = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      run_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      err_reg <= err_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      pwr_reg <= 1'b0;
    end else begin
      pwr_reg <= LOAD_SUPPLY_OK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      st_reg <= 8'h00;
      dg_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      dg_reg <= dg_next;
    end
  end

  // a diagnosed channel is passivated: its process value goes to 0
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      proc_reg <= 8'h00;
    end else begin
      proc_reg <= PROC_SIGNAL & ~CH_DIAG;
    end
  end

  assign RUN_LAMP           = run_reg;
  assign ERROR_LAMP         = err_reg;
  assign SUPPLY_LAMP        = pwr_reg;
  assign CHANNEL_LAMP_N     = st_reg;
  assign CHANNEL_DIAG_LAMP  = dg_reg;
  assign PROC_OUT           = proc_reg;
  assign SUPPLY_FAULT_SHOWN = supply_show;

endmodule // sle_top

// ==== tb/sle_panel.sv ====
// operator view of the front-panel lamps
// assumes lamp inputs straight from sle_top, 1 = lit
module sle_panel (
  input  wire logic       run,
  input  wire logic       err,
  input  wire logic       sup,
  input  wire logic [7:0] st,
  input  wire logic [7:0] dg,
  output logic [18:0]     view
);
  timeunit 1ns;
  timeprecision 1ps;
  // lamps only, no filtering: a glitch is seen as it is
  assign view = {run, err, sup, st, dg};
endmodule // sle_panel

// ==== tb/sle_top_props.sv ====
// lamp encoder checker, bound to sle_top
// assumes one clock and the flash phase from the package
module sle_top_props (
  input wire logic       MCLK,
  input wire logic       RST_B,
  input wire logic       BACKPLANE_OK,
  input wire logic       HW_DEFECT,
  input wire logic       FW_UPDATE,
  input wire logic       ADDR_MISMATCH,
  input wire logic       SUPPLY_ERR,
  input wire logic       NEW_GEN_HOST,
  input wire logic       USER_ACK,
  input wire logic       LOAD_SUPPLY_OK,
  input wire logic [7:0] PROC_SIGNAL,
  input wire logic [7:0] CH_DIAG,
  input wire logic       RUN_LAMP,
  input wire logic       ERROR_LAMP,
  input wire logic       SUPPLY_LAMP,
  input wire logic [7:0] CHANNEL_LAMP_N,
  input wire logic [7:0] CHANNEL_DIAG_LAMP,
  input wire logic [7:0] PROC_OUT,
  input wire logic       SUPPLY_FAULT_SHOWN
);
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  logic up;
  assign up = BACKPLANE_OK && !HW_DEFECT && !FW_UPDATE;
  sequence s_held;
    NEW_GEN_HOST && SUPPLY_ERR ##1 NEW_GEN_HOST && !SUPPLY_ERR;
  endsequence
  property p_dark;
    !BACKPLANE_OK |=> !RUN_LAMP && !ERROR_LAMP && CHANNEL_LAMP_N == 8'h00;
  endproperty
  property p_sup;
    1'b1 |=> SUPPLY_LAMP == $past(LOAD_SUPPLY_OK);
  endproperty
  property p_proc;
    1'b1 |=> PROC_OUT == ($past(PROC_SIGNAL) & ~$past(CH_DIAG));
  endproperty
  property p_hw;
    BACKPLANE_OK && HW_DEFECT |=> RUN_LAMP == ERROR_LAMP;
  endproperty
  property p_fw;
    BACKPLANE_OK && !HW_DEFECT && FW_UPDATE |=> !RUN_LAMP;
  endproperty
  property p_mism;
    up && ADDR_MISMATCH |=> CHANNEL_DIAG_LAMP == 8'hFF;
  endproperty
  property p_hold;
    s_held |-> SUPPLY_FAULT_SHOWN;
  endproperty
  property p_auto;
    !NEW_GEN_HOST ##1 !SUPPLY_ERR |-> !SUPPLY_FAULT_SHOWN;
  endproperty
  a_dark: assert property (p_dark) else $error("lamps lit");
  a_sup: assert property (p_sup) else $error("supply lamp");
  a_proc: assert property (p_proc) else $error("proc out");
  a_hw: assert property (p_hw) else $error("out of step");
  a_fw: assert property (p_fw) else $error("run lit");
  a_mism: assert property (p_mism) else $error("diag dark");
  a_hold: assert property (p_hold) else $error("not held");
  a_auto: assert property (p_auto) else $error("not cleared");
endmodule // sle_top_props

bind sle_top sle_top_props sle_top_props_inst (
  .MCLK(MCLK), .RST_B(RST_B), .BACKPLANE_OK(BACKPLANE_OK),
  .HW_DEFECT(HW_DEFECT), .FW_UPDATE(FW_UPDATE),
  .ADDR_MISMATCH(ADDR_MISMATCH), .SUPPLY_ERR(SUPPLY_ERR),
  .NEW_GEN_HOST(NEW_GEN_HOST), .USER_ACK(USER_ACK),
  .LOAD_SUPPLY_OK(LOAD_SUPPLY_OK), .PROC_SIGNAL(PROC_SIGNAL),
  .CH_DIAG(CH_DIAG), .RUN_LAMP(RUN_LAMP), .ERROR_LAMP(ERROR_LAMP),
  .SUPPLY_LAMP(SUPPLY_LAMP), .CHANNEL_LAMP_N(CHANNEL_LAMP_N),
  .CHANNEL_DIAG_LAMP(CHANNEL_DIAG_LAMP), .PROC_OUT(PROC_OUT),
  .SUPPLY_FAULT_SHOWN(SUPPLY_FAULT_SHOWN));

// ==== tb/sle_top_bench.sv ====
// self-checking bench of sle_top
// flash phase stays 0 in this short run: lamps that flash with the phase read dark, lamps that flash on its inverse read lit
module sle_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // stimulus bits
  // ----
  localparam logic [13:0] BP = 14'h0001, PV = 14'h0002, AD = 14'h0004,
    FW = 14'h0008, HW = 14'h0010, MF = 14'h0020, NG = 14'h0080,
    MA = 14'h0100, MM = 14'h0200, ID = 14'h0400, SE = 14'h0800,
    UA = 14'h1000, LS = 14'h2000, SC = 14'h0040,
    OK = BP | PV | AD | LS;
  localparam logic [7:0] Z = 8'h00, F = 8'hFF;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic [13:0] c = 14'h0000;
  logic [7:0] ps = 8'h00, cd = 8'h00, ap = 8'h00, cw = 8'h00;
  logic rl, el, sl, sh;
  logic [7:0] st, dg, po;
  logic [18:0] view;
  int n_mismatch = 0, num_checks = 0, n_test = 0;
  always #5 MCLK = ~MCLK;
  sle_top sle_top_inst (.MCLK(MCLK), .RST_B(RST_B), .BACKPLANE_OK(c[0]),
    .PARAM_VALID(c[1]), .ADDRESSED(c[2]), .FW_UPDATE(c[3]),
    .HW_DEFECT(c[4]), .MODULE_FAULT(c[5]), .SAFETY_COMM_ERR(c[6]),
    .NEW_GEN_HOST(c[7]), .MODULE_ACK_PEND(c[8]), .ADDR_MISMATCH(c[9]),
    .ADDR_IDENTIFY(c[10]), .SUPPLY_ERR(c[11]), .USER_ACK(c[12]),
    .LOAD_SUPPLY_OK(c[13]), .PROC_SIGNAL(ps), .CH_DIAG(cd),
    .CH_ACK_PEND(ap), .CH_CHAIN_WAIT(cw), .RUN_LAMP(rl),
    .ERROR_LAMP(el), .SUPPLY_LAMP(sl), .CHANNEL_LAMP_N(st),
    .CHANNEL_DIAG_LAMP(dg), .PROC_OUT(po), .SUPPLY_FAULT_SHOWN(sh));
  sle_panel sle_panel_inst (.run(rl), .err(el), .sup(sl), .st(st),
    .dg(dg), .view(view));
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // re = {run, error, fault shown}; two edges let the hold latch settle
  task automatic step(input logic [13:0] cc, input logic [7:0] p, d, a, w,
                      input logic [2:0] re, input logic [7:0] es, ed);
    @(negedge MCLK);
    c = cc;
    ps = p;
    cd = d;
    ap = a;
    cw = w;
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    check({view, po, sh}, {re[2:1], cc[13], es, ed, p & ~d, re[0]});
    n_test++;
    $display("test %0d done", n_test);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #5000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    check({view, po, sh}, 28'h0000000);
    RST_B = 1'b1;
    step(14'h0000, F, Z, Z, Z, 3'b000, Z, Z);
    step(BP | LS, 8'h5A, Z, Z, Z, 3'b000, 8'h5A, Z);
    step(OK, 8'hA5, Z, Z, Z, 3'b100, 8'hA5, Z);
    step(OK | MF, F, 8'h0F, Z, Z, 3'b100, 8'hF0, 8'h0F);
    step(OK | SC, 8'h81, Z, Z, Z, 3'b100, 8'h81, Z);
    step(OK | NG, Z, Z, 8'h01, Z, 3'b100, Z, 8'h01);
    step(OK, Z, Z, 8'h01, 8'h02, 3'b010, Z, 8'h03);
    step(OK | NG | MA, 8'h3C, Z, Z, Z, 3'b010, 8'h3C, Z);
    step(OK | FW | MA, 8'h3C, Z, Z, Z, 3'b000, Z, Z);
    step(OK | HW | FW, 8'h3C, Z, Z, Z, 3'b000, Z, Z);
    step(OK | MM | ID | SE, 8'h3C, Z, Z, Z, 3'b001, Z, F);
    step(OK | ID | SE, 8'h3C, Z, Z, Z, 3'b001, Z, Z);
    step(OK | SE, F, Z, Z, Z, 3'b101, Z, F);
    step(OK, 8'h0F, Z, Z, Z, 3'b100, 8'h0F, Z);
    step(OK | NG | SE | MA, Z, Z, Z, Z, 3'b101, Z, F);
    step(OK | NG, Z, Z, Z, Z, 3'b101, Z, F);
    step(OK | NG | UA, 8'h81, Z, Z, Z, 3'b100, 8'h81, Z);
    stop_test();
  end
endmodule // sle_top_bench
